// [rtl/ps_pointer_sink.sv]
`timescale 1ns/1ps
// Behaviour
// R01: Pointer word from row 4 columns 1, 769.
// R02: Other row 4 pairs are concatenation indicators.
// R03: Interpret pointer to find VC frame start.
// R04: Invalid pointer keeps phase, searches new one.
// R05: Fixed stuff bytes in row 4 ignored.
// R06: Active: deliver payload data, strobe, frame start.
// R07: Inactive: all-ONEs data, no status reporting.
// R08: Alarm defect equals interpreter alarm state.
// R09: Pointer loss defect equals loss state.
// R10: Insert all-ONEs on either defect.
// R11: Server fail downstream on either defect.
// R12: All-ONEs appear within 250 us.
// R13: Recovered data returns within 250 us.
// R14: Alarm cause gated; loss cause follows defect.
// R15: Upstream sends SS=10 and indicator pattern.
// R16: Normal, alarm, loss machine with justifications.
// R17: Trail fail sampled from section input.
module ps_pointer_sink
  import ps_pkg::*;
#(
  parameter int unsigned COLS = PS_COLS
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic ai_clk,
  input wire logic [7:0] ai_data,
  input wire logic ai_fs,
  input wire logic incoming_trail_fail,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] vc_data,
  output logic vc_strobe,
  output logic vc_fs,
  output logic downstream_server_fail,
  output logic alarm_fault_cause_out,
  output logic pointer_loss_fault_cause_out
);

  function automatic logic match3(input logic [3:0] a, input logic [3:0] b);
    logic [3:0] eq;
    eq = ~(a ^ b);
    return (5'(eq[0]) + 5'(eq[1]) + 5'(eq[2]) + 5'(eq[3])) >= 5'h03;
  endfunction

  function automatic logic major5(input logic [4:0] v);
    return (3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]) + 3'(v[4])) >= 3'h3;
  endfunction

  // Link sampling: two stages, then an edge detector on the second
  ps_link_t sync1_reg, sync2_reg, prev_reg;
  ps_link_t link_in;
  assign link_in = '{clk: ai_clk, fs: ai_fs, tsf: incoming_trail_fail, data: ai_data};

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else if (ce) begin
      sync1_reg <= link_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  logic byte_evt;
  logic trail_fail_action;
  assign byte_evt = sync2_reg.clk & ~prev_reg.clk;
  assign trail_fail_action = sync2_reg.tsf; // see R17

  // Frame position
  logic [3:0] row_reg, row_next;
  logic [16:0] col_reg, col_next;
  logic [3:0] row_cur;
  logic [16:0] col_cur;

  always_comb begin
    row_cur = row_reg;
    col_cur = col_reg;
    if (sync2_reg.fs) begin
      row_cur = 4'h1;
      col_cur = 17'h00001;
    end
    row_next = row_reg;
    col_next = col_reg;
    if (byte_evt) begin
      if (col_cur == 17'(COLS)) begin
        col_next = 17'h00001;
        row_next = (row_cur == 4'(PS_ROWS)) ? 4'h1 : row_cur + 4'h1;
      end else begin
        col_next = col_cur + 17'h00001;
        row_next = row_cur;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      row_reg <= 4'h1;
      col_reg <= 17'h00001;
    end else if (ce) begin
      row_reg <= row_next;
      col_reg <= col_next;
    end
  end

  logic in_row4, at_h1, at_h2, in_ci, in_h3, in_stuff, at_pay0, in_pay;
  assign in_row4 = row_cur == PS_PTR_ROW;
  assign at_h1 = byte_evt & in_row4 & (col_cur == PS_H1_COL); // see R01
  assign at_h2 = byte_evt & in_row4 & (col_cur == PS_H2_COL); // see R01
  // Indicator and fixed stuff columns of row 4 carry no data and are never decoded
  assign in_ci = in_row4 & ((col_cur > PS_H1_COL && col_cur <= PS_CI1_LAST) ||
                 (col_cur >= PS_CI2_FIRST && col_cur <= PS_CI2_LAST)); // see R02
  assign in_h3 = in_row4 & (col_cur >= PS_H3_FIRST) & (col_cur <= PS_H3_LAST);
  assign in_stuff = in_row4 & (col_cur >= PS_PAY_FIRST) & (col_cur <= PS_STUFF_LAST);
  assign at_pay0 = in_row4 & (col_cur == PS_PAY_FIRST);
  assign in_pay = col_cur >= PS_PAY_FIRST; // see R05

  // Pointer interpreter
  ps_state_t state_reg, state_next;
  logic [9:0] ptr_reg, ptr_next, cand_reg, cand_next;
  logic [7:0] h1_reg, h1_next;
  logic [3:0] ais_cnt_reg, ais_cnt_next, inv_cnt_reg, inv_cnt_next, new_cnt_reg, new_cnt_next;
  logic inc_reg, inc_next, dec_reg, dec_next;
  logic [15:0] word;
  logic [9:0] val, diff;
  logic ndf_norm, ndf_en, ss_ok, in_range, valid, is_ais, inc_pat, dec_pat;

  assign word = {h1_reg, sync2_reg.data};
  assign val = word[9:0];
  assign diff = val ^ ptr_reg;
  assign ndf_norm = match3(word[15:12], PS_NDF_NORMAL);
  assign ndf_en = match3(word[15:12], PS_NDF_ENABLE);
  assign ss_ok = word[11:10] == PS_SS_AU;
  assign in_range = val <= PS_PTR_MAX;
  assign valid = ndf_norm & ss_ok & in_range;
  assign is_ais = word == PS_AIS_WORD;
  assign inc_pat = ndf_norm & ss_ok & major5({diff[9], diff[7], diff[5], diff[3], diff[1]}) &
                   ~major5({diff[8], diff[6], diff[4], diff[2], diff[0]});
  assign dec_pat = ndf_norm & ss_ok & major5({diff[8], diff[6], diff[4], diff[2], diff[0]}) &
                   ~major5({diff[9], diff[7], diff[5], diff[3], diff[1]});

  always_comb begin
    state_next = state_reg;
    ptr_next = ptr_reg;
    cand_next = cand_reg;
    h1_next = h1_reg;
    ais_cnt_next = ais_cnt_reg;
    inv_cnt_next = inv_cnt_reg;
    new_cnt_next = new_cnt_reg;
    inc_next = inc_reg;
    dec_next = dec_reg;
    if (sync2_reg.fs) begin
      inc_next = 1'b0;
      dec_next = 1'b0;
    end
    if (at_h1) begin
      h1_next = sync2_reg.data;
    end
    if (at_h2) begin // see R03
      if (is_ais) begin // see R16
        ais_cnt_next = ais_cnt_reg + 4'h1;
        inv_cnt_next = 4'h0;
        new_cnt_next = 4'h0;
        if (ais_cnt_next >= PS_AIS_ENTRY) begin
          state_next = PS_AIS;
        end
      end else begin
        ais_cnt_next = 4'h0;
        if (state_reg == PS_NORM && valid && val == ptr_reg) begin
          inv_cnt_next = 4'h0;
          new_cnt_next = 4'h0;
        end else if (state_reg == PS_NORM && inc_pat) begin // see R16
          ptr_next = (ptr_reg == PS_PTR_MAX) ? 10'h000 : ptr_reg + 10'h001;
          inc_next = 1'b1;
          inv_cnt_next = 4'h0;
          new_cnt_next = 4'h0;
        end else if (state_reg == PS_NORM && dec_pat) begin // see R16
          ptr_next = (ptr_reg == 10'h000) ? PS_PTR_MAX : ptr_reg - 10'h001;
          dec_next = 1'b1;
          inv_cnt_next = 4'h0;
          new_cnt_next = 4'h0;
        end else if (ndf_en && ss_ok && in_range) begin // see R16
          ptr_next = val;
          state_next = PS_NORM;
          inv_cnt_next = 4'h0;
          new_cnt_next = 4'h0;
        end else if (valid) begin
          // Old phase stays in use while a new candidate proves itself
          new_cnt_next = (val == cand_reg) ? new_cnt_reg + 4'h1 : 4'h1; // see R04
          cand_next = val;
          inv_cnt_next = inv_cnt_reg + 4'h1;
          if (new_cnt_next >= PS_NEW_ACCEPT) begin
            ptr_next = val;
            state_next = PS_NORM;
            inv_cnt_next = 4'h0;
            new_cnt_next = 4'h0;
          end
        end else begin
          inv_cnt_next = inv_cnt_reg + 4'h1;
          new_cnt_next = 4'h0;
        end
        if (inv_cnt_next >= PS_LOP_ENTRY && state_next != PS_NORM ||
            inv_cnt_next >= PS_LOP_ENTRY && state_reg == PS_NORM) begin
          state_next = PS_LOP;
          inv_cnt_next = PS_LOP_ENTRY;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= PS_LOP;
      ptr_reg <= PS_PTR_RESET;
      cand_reg <= PS_PTR_RESET;
      h1_reg <= 8'h00;
      ais_cnt_reg <= 4'h0;
      inv_cnt_reg <= 4'h0;
      new_cnt_reg <= 4'h0;
      inc_reg <= 1'b0;
      dec_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      ptr_reg <= ptr_next;
      cand_reg <= cand_next;
      h1_reg <= h1_next;
      ais_cnt_reg <= ais_cnt_next;
      inv_cnt_reg <= inv_cnt_next;
      new_cnt_reg <= new_cnt_next;
      inc_reg <= inc_next;
      dec_reg <= dec_next;
    end
  end

  logic alarm_indication_defect, pointer_loss_defect, all_ones_insert_action, server_fail_action;
  logic function_activation_control, alarm_report_enable;
  assign alarm_indication_defect = state_reg == PS_AIS; // see R08
  assign pointer_loss_defect = state_reg == PS_LOP; // see R09
  assign all_ones_insert_action = alarm_indication_defect | pointer_loss_defect; // see R10
  assign server_fail_action = alarm_indication_defect | pointer_loss_defect; // see R11

  // Payload extraction
  logic [19:0] pos_reg, pos_next, start_pos;
  logic [7:0] data_reg, data_next;
  logic strobe_reg, strobe_next, fs_reg, fs_next;
  logic pay_byte;
  assign start_pos = 20'({ptr_reg, 9'h000}) + 20'({ptr_reg, 8'h00}); // see R03
  assign pay_byte = byte_evt & ~in_ci & ((in_pay & ~(in_stuff & inc_reg)) | (in_h3 & dec_reg)); // see R16

  always_comb begin
    pos_next = pos_reg;
    data_next = data_reg;
    strobe_next = 1'b0;
    fs_next = 1'b0;
    if (byte_evt && in_pay) begin
      pos_next = at_pay0 ? 20'h00001 : pos_reg + 20'h00001;
    end
    if (pay_byte) begin // see R06
      strobe_next = 1'b1;
      fs_next = in_pay & ((at_pay0 ? 20'h00000 : pos_reg) == start_pos);
      // All-ONEs take over on the next byte, well inside the allowed delay
      data_next = (all_ones_insert_action || !function_activation_control) ? 8'hff : sync2_reg.data; // see R12
    end else if (!function_activation_control || all_ones_insert_action) begin
      data_next = 8'hff; // see R07
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pos_reg <= 20'h00000;
      data_reg <= 8'hff;
      strobe_reg <= 1'b0;
      fs_reg <= 1'b0;
    end else if (ce) begin
      pos_reg <= pos_next;
      data_reg <= data_next; // see R13
      strobe_reg <= strobe_next;
      fs_reg <= fs_next;
    end
  end

  assign vc_data = data_reg;
  assign vc_strobe = strobe_reg;
  assign vc_fs = fs_reg;
  assign downstream_server_fail = server_fail_action;

  // Fault causes, silenced while the function is inactive
  logic alarm_fault_cause, pointer_loss_fault_cause;
  assign alarm_fault_cause = alarm_indication_defect & ~trail_fail_action & alarm_report_enable; // see R14
  assign pointer_loss_fault_cause = pointer_loss_defect; // see R14
  assign alarm_fault_cause_out = alarm_fault_cause & function_activation_control; // see R07
  assign pointer_loss_fault_cause_out = pointer_loss_fault_cause & function_activation_control; // see R07

  // APB register slave
  logic [1:0] ctrl_reg, ctrl_next;
  logic [31:0] rdata, prdata_reg, prdata_next;
  logic mapped, wr_en;
  assign function_activation_control = ctrl_reg[PS_CTRL_ACTIVE_BIT];
  assign alarm_report_enable = ctrl_reg[PS_CTRL_REPORT_BIT];
  assign mapped = (paddr == PS_CTRL_OFS) | (paddr == PS_STATUS_OFS) | (paddr == PS_PTR_OFS);
  assign wr_en = psel & penable & pwrite & ce & (paddr == PS_CTRL_OFS);
  assign pready = ce;
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    ctrl_next = wr_en ? pwdata[1:0] : ctrl_reg;
    rdata = 32'h00000000;
    unique case (paddr)
      PS_CTRL_OFS: rdata = {30'h00000000, ctrl_reg};
      PS_STATUS_OFS: rdata = {25'h0000000, state_reg, trail_fail_action, pointer_loss_fault_cause_out,
                              alarm_fault_cause_out, pointer_loss_defect, alarm_indication_defect};
      PS_PTR_OFS: rdata = {22'h000000, ptr_reg};
      default: rdata = 32'h00000000;
    endcase
    prdata_next = (psel && !penable) ? rdata : prdata_reg;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_reg <= PS_CTRL_RESET;
      prdata_reg <= 32'h00000000;
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;

endmodule

// [rtl/ps_pkg.sv]
package ps_pkg;
  // Frame geometry of the multiplex section stream
  localparam int unsigned PS_ROWS = 9;
  localparam int unsigned PS_COLS = 69120;
  localparam logic [3:0] PS_PTR_ROW = 4'h4;
  localparam logic [16:0] PS_H1_COL = 17'h00001;
  localparam logic [16:0] PS_H2_COL = 17'h00301;
  localparam logic [16:0] PS_CI1_LAST = 17'h00100;
  localparam logic [16:0] PS_CI2_FIRST = 17'h00302;
  localparam logic [16:0] PS_CI2_LAST = 17'h00400;
  localparam logic [16:0] PS_H3_FIRST = 17'h00601;
  localparam logic [16:0] PS_H3_LAST = 17'h00900;
  localparam logic [16:0] PS_PAY_FIRST = 17'h00901;
  localparam logic [16:0] PS_STUFF_LAST = 17'h00c00;
  // Pointer word coding
  localparam logic [3:0] PS_NDF_NORMAL = 4'h6;
  localparam logic [3:0] PS_NDF_ENABLE = 4'h9;
  localparam logic [1:0] PS_SS_AU = 2'h2;
  localparam logic [15:0] PS_AIS_WORD = 16'hffff;
  localparam logic [9:0] PS_PTR_MAX = 10'h30e;
  localparam logic [9:0] PS_PTR_RESET = 10'h000;
  // Consecutive pointer counts of the interpreter
  localparam logic [3:0] PS_AIS_ENTRY = 4'h3;
  localparam logic [3:0] PS_NEW_ACCEPT = 4'h3;
  localparam logic [3:0] PS_LOP_ENTRY = 4'h8;
  // Register map (byte addresses)
  localparam logic [11:0] PS_CTRL_OFS = 12'h000;
  localparam logic [11:0] PS_STATUS_OFS = 12'h004;
  localparam logic [11:0] PS_PTR_OFS = 12'h008;
  localparam logic [1:0] PS_CTRL_RESET = 2'h0;
  localparam int unsigned PS_CTRL_ACTIVE_BIT = 0;
  localparam int unsigned PS_CTRL_REPORT_BIT = 1;

  typedef enum logic [1:0] {
    PS_NORM = 2'b00,
    PS_AIS = 2'b01,
    PS_LOP = 2'b10
  } ps_state_t;

  typedef struct packed {
    logic clk;
    logic fs;
    logic tsf;
    logic [7:0] data;
  } ps_link_t;
endpackage

// [verif/ps_pointer_sink_properties.sv]
`timescale 1ns/1ps
module ps_sink_props
  import ps_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic incoming_trail_fail,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [7:0] vc_data,
  input wire logic vc_strobe,
  input wire logic vc_fs,
  input wire logic downstream_server_fail,
  input wire logic alarm_fault_cause_out,
  input wire logic pointer_loss_fault_cause_out
);
  // Shadow of the control register, rebuilt from completed writes
  logic [1:0] ctrl_reg, ctrl_next;
  always_comb begin
    ctrl_next = ctrl_reg;
    if (psel && penable && pready && pwrite && paddr == PS_CTRL_OFS) ctrl_next = pwdata[1:0];
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) ctrl_reg <= PS_CTRL_RESET;
    else ctrl_reg <= ctrl_next;
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  AST_SSF_ONES: assert property (vc_strobe && $past(downstream_server_fail) |-> vc_data == 8'hff)
    else $error("payload not all ones during fail");
  AST_OFF_ONES: assert property (vc_strobe && !$past(ctrl_reg[0]) |-> vc_data == 8'hff)
    else $error("payload not all ones while inactive");
  AST_OFF_QUIET: assert property (!ctrl_reg[0] |-> !alarm_fault_cause_out && !pointer_loss_fault_cause_out)
    else $error("cause reported while inactive");
  AST_CAUSE_EXCL: assert property (!(alarm_fault_cause_out && pointer_loss_fault_cause_out))
    else $error("both causes at once");
  AST_CAUSE_SSF: assert property (alarm_fault_cause_out || pointer_loss_fault_cause_out |-> downstream_server_fail)
    else $error("cause without server fail");
  AST_ALARM_GATE: assert property (alarm_fault_cause_out |-> ctrl_reg == 2'h3)
    else $error("alarm cause without enables");
  AST_TSF_GATE: assert property (incoming_trail_fail [*4] |-> !alarm_fault_cause_out)
    else $error("alarm cause during trail fail");
  AST_FS_STROBE: assert property (vc_fs |-> vc_strobe ##1 !vc_strobe [*5])
    else $error("frame start without single strobe");
  cover property (vc_fs);
  cover property (alarm_fault_cause_out);
  cover property (pointer_loss_fault_cause_out);
endmodule

// [verif/ps_stream_model.sv]
`timescale 1ns/1ps
module ps_stream_model
  import ps_pkg::*;
#(
  parameter int unsigned COLS = PS_COLS,
  parameter int unsigned LAST_COL = 2320
) (
  input wire logic run,
  input wire logic [15:0] ptr_word,
  input wire logic tsf,
  output ps_link_t link,
  output logic [7:0] frames
);
  function automatic logic [7:0] byte_at(input int unsigned r, input int unsigned c);
    if (r == 4 && c == 1) return ptr_word[15:8];
    if (r == 4 && c == 769) return ptr_word[7:0];
    if (r == 4 && c <= 256) return 8'h93;
    if (r == 4 && c >= 770 && c <= 1024) return 8'hff;
    if (r == 4 && c <= 1536) return 8'(c) ^ frames; // Stuff carries junk
    return 8'h5a;
  endfunction
  // Frames stop at column 2320 of the pointer row to keep runs short; clock stands still when idle
  initial begin
    link = '0;
    frames = 8'h00;
    #3;
    forever begin
      wait (run);
      for (int r = 1; r <= 4; r++) begin
        for (int c = 1; c <= COLS && (r < 4 || c <= LAST_COL); c++) begin
          link.clk = 1'b0;
          link.fs = (r == 1 && c == 1);
          link.tsf = tsf;
          link.data = byte_at(r, c);
          #40;
          link.clk = 1'b1;
          #40;
        end
      end
      frames = frames + 8'h01;
    end
  end
endmodule

// [verif/ps_pointer_sink_tb_top.sv]
`timescale 1ns/1ps
module ps_pointer_sink_tb_top
  import ps_pkg::*;
;
  localparam int unsigned COLS = 3080;
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, vc_strobe, vc_fs, ssf, alarm, ploss, run, tsf;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] vc_data, frames, fs_data;
  logic [15:0] ptr_word;
  ps_link_t link;
  int unsigned bad_count, n_tests, fs_cnt, cyc;
  ps_stream_model #(.COLS(COLS)) u_model (.run(run), .ptr_word(ptr_word), .tsf(tsf), .link(link), .frames(frames));
  ps_pointer_sink #(.COLS(COLS)) u_dut (
    .clk_sys(clk_sys), .reset(reset), .ce(1'b1), .ai_clk(link.clk), .ai_data(link.data), .ai_fs(link.fs),
    .incoming_trail_fail(link.tsf), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .vc_data(vc_data), .vc_strobe(vc_strobe),
    .vc_fs(vc_fs), .downstream_server_fail(ssf), .alarm_fault_cause_out(alarm),
    .pointer_loss_fault_cause_out(ploss));
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (vc_fs === 1'b1) fs_cnt++;
    if (vc_fs === 1'b1) fs_data <= vc_data;
    if (cyc == 1200000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Read compares against d; write sends d
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic e);
    int unsigned n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    if (!wr) chk(prdata, d);
    chk(32'(pslverr), 32'(e));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic next_byte();
    int unsigned n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (vc_strobe !== 1'b1 && n < 30000);
    if (n >= 30000) bad_count++;
  endtask
  task automatic wait_frames(input int unsigned k);
    logic [7:0] f0;
    f0 = frames;
    wait (frames == f0 + 8'(k));
  endtask
  task automatic t_reset();
    chk(32'(ssf), 32'h1);
    apb(1'b0, PS_CTRL_OFS, 32'h0, 1'b0);
    apb(1'b1, PS_STATUS_OFS, 32'hffff_ffff, 1'b0);
    apb(1'b0, PS_STATUS_OFS, 32'h42, 1'b0);
    apb(1'b0, 12'h00c, 32'h0, 1'b1);
  endtask
  task automatic t_lop();
    apb(1'b1, PS_CTRL_OFS, 32'h3, 1'b0);
    apb(1'b0, PS_STATUS_OFS, 32'h4a, 1'b0);
    chk(32'(ploss), 32'h1);
  endtask
  task automatic t_norm();
    run = 1'b1;
    wait_frames(3);
    apb(1'b0, PS_STATUS_OFS, 32'h0, 1'b0);
    apb(1'b0, PS_PTR_OFS, 32'h0, 1'b0);
    chk(32'(fs_cnt > 0), 32'h1);
    chk(32'(fs_data), 32'h5a);
  endtask
  task automatic t_ais();
    ptr_word = PS_AIS_WORD;
    wait_frames(3);
    apb(1'b0, PS_STATUS_OFS, 32'h25, 1'b0);
    chk(32'(ssf), 32'h1);
    chk(32'(alarm), 32'h1);
    next_byte();
    chk(32'(vc_data), 32'hff);
    tsf <= 1'b1;
    repeat (100) @(posedge clk_sys);
    apb(1'b0, PS_STATUS_OFS, 32'h31, 1'b0);
    tsf <= 1'b0;
    repeat (20) @(posedge clk_sys);
    apb(1'b1, PS_CTRL_OFS, 32'h1, 1'b0);
    apb(1'b0, PS_STATUS_OFS, 32'h21, 1'b0);
  endtask
  task automatic t_recover();
    ptr_word = 16'h9805;
    wait_frames(1);
    ptr_word = 16'h6805;
    wait_frames(1);
    apb(1'b0, PS_STATUS_OFS, 32'h0, 1'b0);
    apb(1'b0, PS_PTR_OFS, 32'h5, 1'b0);
    chk(32'(ssf), 32'h0);
    next_byte();
    next_byte();
    chk(32'(vc_data), 32'h5a);
  endtask
  task automatic t_invalid();
    ptr_word = 16'h6806;
    wait_frames(1);
    ptr_word = 16'h6805;
    apb(1'b0, PS_STATUS_OFS, 32'h0, 1'b0);
    apb(1'b0, PS_PTR_OFS, 32'h5, 1'b0);
  endtask
  task automatic t_inc();
    ptr_word = 16'h6aaf;
    wait_frames(1);
    ptr_word = 16'h6806;
    apb(1'b0, PS_PTR_OFS, 32'h6, 1'b0);
    apb(1'b0, PS_STATUS_OFS, 32'h0, 1'b0);
  endtask
  task automatic t_off();
    apb(1'b1, PS_CTRL_OFS, 32'h0, 1'b0);
    next_byte();
    next_byte();
    chk(32'(vc_data), 32'hff);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    {psel, penable, pwrite, run, tsf} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    ptr_word = 16'h6800;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_lop();
    t_norm();
    t_ais();
    t_recover();
    t_invalid();
    t_inc();
    t_off();
    end_sim();
  end
endmodule
bind ps_pointer_sink ps_sink_props u_props (.clk_sys(clk_sys), .reset(reset),
  .incoming_trail_fail(incoming_trail_fail), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .vc_data(vc_data), .vc_strobe(vc_strobe), .vc_fs(vc_fs),
  .downstream_server_fail(downstream_server_fail), .alarm_fault_cause_out(alarm_fault_cause_out),
  .pointer_loss_fault_cause_out(pointer_loss_fault_cause_out));
